// *** phy_ext_ctrl_defines.svh ***
// Constants for the per-port extended control and interrupt mask register bank
// Function
// - Bit 12 selects SGMII or 1000BASE-X
// - Bit 11 chooses copper or SerDes preference
// - Bits 10:8 media mode, 100 reserved
// - Bits 7:6 force media selection override
// - Mode bits read back mode in force
// - Bits 15:13 edge-rate code, reset 000
// - Jumbo code 01 gives 9 kB
// - Jumbo code 10 gives 12 kB
// - Longer limits need tighter reference clock
// - Mask bits enable causes, bit 6 reserved
// - Pin enable makes pin follow summary
// - Pin enable clear keeps causes latching
// - Super-persistent bits survive software reset always
// - Persistent bits survive only when enabled
// - Status bits clear on read, summary bit15
`ifndef PHY_EXT_CTRL_DEFINES_SVH
`define PHY_EXT_CTRL_DEFINES_SVH
`define REG_MODE_CTRL      5'h17
`define REG_EDGE_CTRL      5'h18
`define REG_IRQ_MASK       5'h19
`define REG_IRQ_STATUS     5'h1A
`define MODE_WR_MASK       16'hFFC8
`define MODE_LIVE_MASK     16'h00C8
`define EDGE_WR_MASK       16'hF031
`define EDGE_STICKY_MASK   16'hF030
`define MASK_WR_MASK       16'hFFBF
`define CAUSE_MASK         16'h7FBF
`define MODE_RESET         16'h0000
`define EDGE_RESET         16'h0000
`define MASK_RESET         16'h0000
`define PIN_EN_BIT         15
`define JUMBO_LSB          4
`define MODE_LSB           8
`endif

// *** phy_ext_ctrl_pkg.sv ***
// Types for the extended control register bank
package phy_ext_ctrl_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_s;
    typedef struct packed {
        logic        mac_if_1000x;
        logic        prefer_copper;
        logic [2:0]  media_mode;
        logic [1:0]  ams_override;
        logic        far_loop;
        logic [2:0]  edge_rate;
        logic        reduced_power;
        logic [1:0]  jumbo_mode;
        logic        conn_loop;
    } mode_cfg_s;
    typedef enum logic [1:0] {JUMBO_STD, JUMBO_9K, JUMBO_12K, JUMBO_RSV} jumbo_e;
endpackage

// *** phy_ext_ctrl.sv ***
// Extended control, media mode and interrupt mask register bank for one PHY port
`timescale 1ns/1ps
`include "phy_ext_ctrl_defines.svh"
module phy_ext_ctrl
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire phy_ext_ctrl_pkg::mgmt_req_s req,
    input  wire logic                        soft_reset,
    input  wire logic                        sticky_enable,
    input  wire logic [15:0]                 cause_events,
    output logic [15:0]                      rdata,
    output phy_ext_ctrl_pkg::mode_cfg_s      cfg,
    output logic [15:0]                      jumbo_max_kb,
    output logic [15:0]                      jumbo_max_kb_tight,
    output logic                             mgmt_interrupt_pin
);
    // ****************************************
    // Register storage
    // ****************************************
    logic [15:0] mode_pend_q;
    logic [15:0] mode_pend_d;
    logic [15:0] mode_live_q;
    logic [15:0] mode_live_d;
    logic [15:0] edge_q;
    logic [15:0] edge_d;
    logic [15:0] mask_q;
    logic [15:0] mask_d;
    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [15:0] rdata_d;
    logic        pin_d;
    phy_ext_ctrl_pkg::mode_cfg_s cfg_d;
    logic [15:0] jmax_d;
    logic [15:0] jmax_t_d;

    // Write strobes for mode, edge and mask registers; read strobe for status only
    wire wr_mode   = req.wr && (req.addr == `REG_MODE_CTRL);
    wire wr_edge   = req.wr && (req.addr == `REG_EDGE_CTRL);
    wire wr_mask   = req.wr && (req.addr == `REG_IRQ_MASK);
    wire rd_status = req.rd && (req.addr == `REG_IRQ_STATUS);
    wire [15:0] wmode = req.wdata & `MODE_WR_MASK;
    wire [15:0] wedge = req.wdata & `EDGE_WR_MASK;
    wire [15:0] wmask = req.wdata & `MASK_WR_MASK;

    // Pending mode holds written value; super-persistent fields ignore soft reset
    assign mode_pend_d = wr_mode ? wmode : mode_pend_q;
    // Mode bits 13:8 only take effect on soft reset; override and loopback act at once
    // Live override bits follow writes only, so a soft reset clear is not undone later
    wire [15:0] live_wr   = (mode_live_q & ~`MODE_LIVE_MASK) | (wmode & `MODE_LIVE_MASK);
    assign mode_live_d = soft_reset ? (mode_pend_q & `MODE_WR_MASK & ~`MODE_LIVE_MASK)
                       : (wr_mode ? live_wr : mode_live_q);
    // Persistent bits reset to default unless enable is set; non-sticky always reset
    wire [15:0] edge_sr = sticky_enable ? (edge_q & `EDGE_STICKY_MASK) : `EDGE_RESET;
    assign edge_d = soft_reset ? edge_sr : (wr_edge ? wedge : edge_q);
    assign mask_d = soft_reset ? (sticky_enable ? mask_q : `MASK_RESET)
                  : (wr_mask ? wmask : mask_q);

    // Causes always latch regardless of pin enable; a set in the read cycle wins
    wire [15:0] ev_latched = cause_events & `CAUSE_MASK & mask_q;
    wire [14:0] kept = rd_status ? 15'h0000 : status_q[14:0];
    wire [14:0] cause_d = kept | ev_latched[14:0];
    assign status_d = {|cause_d, cause_d};
    // Pin follows summary only while enabled
    assign pin_d = mask_q[`PIN_EN_BIT] & status_q[15];

    // Read data mux; mode register shows live mode
    wire [15:0] mode_rd = (mode_pend_q & ~16'h3FC8 & `MODE_WR_MASK) | (mode_live_q & 16'h3FC8);
    assign rdata_d = (req.addr == `REG_MODE_CTRL)  ? mode_rd :
                     (req.addr == `REG_EDGE_CTRL)  ? edge_q :
                     (req.addr == `REG_IRQ_MASK)   ? mask_q :
                     (req.addr == `REG_IRQ_STATUS) ? status_q : 16'h0000;

    // Decoded configuration from registers in force
    assign cfg_d.mac_if_1000x  = mode_live_q[12];
    assign cfg_d.prefer_copper = mode_live_q[11];
    assign cfg_d.media_mode    = (mode_live_q[10:8] == 3'h4) ? 3'h0 : mode_live_q[10:8];
    assign cfg_d.ams_override  = (mode_live_q[7:6] == 2'h3) ? 2'h0 : mode_live_q[7:6];
    assign cfg_d.far_loop      = mode_live_q[3];
    assign cfg_d.edge_rate     = edge_q[15:13];
    assign cfg_d.reduced_power = edge_q[12];
    assign cfg_d.jumbo_mode    = edge_q[5:4];
    assign cfg_d.conn_loop     = edge_q[0];

    // Jumbo length limits at 100 ppm and at tighter clock offset
    wire [1:0] jm = edge_q[`JUMBO_LSB +: 2];
    assign jmax_d   = (jm == 2'h1) ? 16'h0009 : (jm == 2'h2) ? 16'h000C : 16'h0001;
    assign jmax_t_d = (jm == 2'h1) ? 16'h000C : (jm == 2'h2) ? 16'h0010 : 16'h0001;

    // ****************************************
    // Flops
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_pend_q <= `MODE_RESET;
            mode_live_q <= `MODE_RESET;
            edge_q <= `EDGE_RESET;
            mask_q <= `MASK_RESET;
            status_q <= 16'h0000;
        end
        else
        begin
            mode_pend_q <= mode_pend_d;
            mode_live_q <= mode_live_d;
            edge_q <= edge_d;
            mask_q <= mask_d;
            status_q <= status_d;
        end
    end

    // Outputs registered so pins never glitch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 16'h0000;
            cfg <= '0;
            jumbo_max_kb <= 16'h0001;
            jumbo_max_kb_tight <= 16'h0001;
            mgmt_interrupt_pin <= 1'b0;
        end
        else
        begin
            rdata <= rdata_d;
            cfg <= cfg_d;
            jumbo_max_kb <= jmax_d;
            jumbo_max_kb_tight <= jmax_t_d;
            mgmt_interrupt_pin <= pin_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_pin_follows: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> mgmt_interrupt_pin == $past(mask_q[15] & status_q[15]))
        else $error("pin not following summary");
    a_pin_gated: assert property (@(posedge clk) disable iff (!rst_n)
        !mask_q[15] |=> !mgmt_interrupt_pin) else $error("pin asserted while disabled");
    a_cause_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (cause_events[0] && mask_q[0]) |=> status_q[0]) else $error("cause lost");
    a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_status && !(|(cause_events & mask_q & `CAUSE_MASK))) |=> status_q == 16'h0000)
        else $error("status not cleared by read");
    a_summary_any: assert property (@(posedge clk) disable iff (!rst_n)
        status_q[15] == (|status_q[14:0])) else $error("summary mismatch");
    a_mode_pending: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_mode && !soft_reset) |=> $stable(mode_live_q[13:8])) else $error("mode changed early");
    a_mode_apply: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset |=> mode_live_q[13:8] == $past(mode_pend_q[13:8])) else $error("mode not applied");
    a_super_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (soft_reset && !wr_mode) |=> mode_pend_q == $past(mode_pend_q)) else $error("super bits lost");
    a_sticky_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (soft_reset && !sticky_enable) |=> mask_q == 16'h0000 && edge_q == 16'h0000)
        else $error("sticky bits kept");
    a_rsv_zero: assert property (@(posedge clk) disable iff (!rst_n)
        mask_q[6] == 1'b0 && status_q[6] == 1'b0) else $error("reserved bit set");
    a_jumbo_9k: assert property (@(posedge clk) disable iff (!rst_n)
        (edge_q[5:4] == 2'h1) |=> jumbo_max_kb == 16'h0009) else $error("jumbo limit wrong");
    c_pin_fire: cover property (@(posedge clk) disable iff (!rst_n) mgmt_interrupt_pin);
    c_mode_swap: cover property (@(posedge clk) disable iff (!rst_n) wr_mode ##[1:20] soft_reset);
    c_read_clear: cover property (@(posedge clk) disable iff (!rst_n) status_q[15] ##1 rd_status);
endmodule

// *** mgmt_station.sv ***
// Station manager model issuing register requests to the extended control bank
`timescale 1ns/1ps
module mgmt_station
(
    input  wire logic                   clk,
    input  wire logic [15:0]            rdata,
    output phy_ext_ctrl_pkg::mgmt_req_s req,
    output logic                        soft_reset
);
    // Idle bus; every request is launched on a falling edge
    initial
    begin
        req = '0;
        soft_reset = 1'b0;
    end
    // One-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    // Read strobe only on the status register, since it clears what it reads
    task automatic rd(input logic [4:0] a, input logic c, output logic [15:0] d);
        @(negedge clk);
        req.addr = a;
        req.rd = c;
        @(negedge clk);
        req.rd = 1'b0;
        d = rdata;
    endtask
    // Pending mode bits only land on this pulse
    task automatic sreset();
        @(negedge clk);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
    endtask
endmodule

// *** phy_ext_control_irq_mask_bench.sv ***
// Self-checking bench for the extended control and interrupt mask bank
`timescale 1ns/1ps
module phy_ext_control_irq_mask_bench;
    logic                        clk;
    logic                        rst_n;
    logic                        soft_reset;
    logic                        sticky_enable;
    logic                        pin;
    logic [15:0]                 cause_events;
    logic [15:0]                 rdata;
    logic [15:0]                 jumbo_max_kb;
    logic [15:0]                 jumbo_max_kb_tight;
    logic [15:0]                 v;
    logic [15:0]                 kb  [4] = '{16'h0001, 16'h0009, 16'h000C, 16'h0001};
    logic [15:0]                 kbt [4] = '{16'h0001, 16'h000C, 16'h0010, 16'h0001};
    int                          fail_count = 0;
    int                          checks = 0;
    phy_ext_ctrl_pkg::mgmt_req_s req;
    phy_ext_ctrl_pkg::mode_cfg_s cfg;
    mgmt_station mgr (.clk(clk), .rdata(rdata), .req(req), .soft_reset(soft_reset));
    phy_ext_ctrl uut (.clk(clk), .rst_n(rst_n), .req(req), .soft_reset(soft_reset),
        .sticky_enable(sticky_enable), .cause_events(cause_events), .rdata(rdata), .cfg(cfg),
        .jumbo_max_kb(jumbo_max_kb), .jumbo_max_kb_tight(jumbo_max_kb_tight), .mgmt_interrupt_pin(pin));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        mgr.rd(a, a == 5'h1A, v);
        chk(v, exp);
    endtask
    // One-cycle cause pulse
    task automatic pulse(input logic [15:0] e);
        @(negedge clk);
        cause_events = e;
        @(negedge clk);
        cause_events = '0;
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard: the sequence needs under a hundred cycles; the guard fires after 1000
    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        rst_n = 1'b0;
        sticky_enable = 1'b0;
        cause_events = '0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rchk(5'h17, 16'h0000);
        rchk(5'h18, 16'h0000);
        chk(jumbo_max_kb, 16'h0001);
        mgr.wr(5'h19, 16'hFFFF);
        rchk(5'h19, 16'hFFBF);
        rchk(5'h1F, 16'h0000);
        // Mode bits stay hidden until the software reset
        mgr.wr(5'h17, 16'h1D40);
        rchk(5'h17, 16'h0040);
        chk({14'h0000, cfg.ams_override}, 16'h0001);
        mgr.sreset();
        rchk(5'h17, 16'h1D00);
        chk({11'h000, cfg.mac_if_1000x, cfg.prefer_copper, cfg.media_mode}, 16'h001D);
        rchk(5'h19, 16'h0000);
        // Every jumbo code, reserved one included
        for (int i = 0; i < 4; i++)
        begin
            mgr.wr(5'h18, {3'b010, 7'h00, i[1:0], 4'h1});
            rchk(5'h18, {3'b010, 7'h00, i[1:0], 4'h1});
            chk(jumbo_max_kb, kb[i]);
            chk(jumbo_max_kb_tight, kbt[i]);
        end
        chk({13'h0000, cfg.edge_rate}, 16'h0002);
        sticky_enable = 1'b1;
        mgr.wr(5'h19, 16'h0001);
        mgr.sreset();
        rchk(5'h18, 16'h4030);
        rchk(5'h19, 16'h0001);
        // Pin disabled: causes still latch, masked ones do not
        rchk(5'h1A, 16'h0000);
        pulse(16'h0003);
        chk({15'h0000, pin}, 16'h0000);
        rchk(5'h1A, 16'h8001);
        rchk(5'h1A, 16'h0000);
        mgr.wr(5'h19, 16'h8001);
        pulse(16'h0001);
        @(negedge clk);
        chk({15'h0000, pin}, 16'h0001);
        rchk(5'h1A, 16'h8001);
        @(negedge clk);
        chk({15'h0000, pin}, 16'h0000);
        tally_and_finish();
    end
endmodule
